/* File: core/lcs_cluster.sv */
// Logic cluster: four slices of two function generators and two storage elements,
// distributed memory organisation and an APB register file for configuration.
// Assumes user logic on pclk drives all fabric-side inputs; none are synchronised.
`timescale 1ns/1ps

module lcs_cluster (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [31:0] read_address_input,
  input wire logic [7:0] shift_en,
  input wire logic [7:0] shift_in,
  input wire logic [6:0] ram_addr,
  input wire logic [5:0] ram_dpra,
  input wire logic [7:0] ram_wdata,
  input wire logic [3:0] set_reset_input,
  input wire logic [3:0] set_input,
  input wire logic [3:0] latch_gate,
  output logic [7:0] fg_out,
  output logic [7:0] shift_out,
  output logic [7:0] ram_spo,
  output logic [3:0] ram_dpo,
  output logic [7:0] se_q
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  lcs_pkg::lcs_top_state_t st_r;
  lcs_pkg::lcs_top_state_t st_nxt;
  lcs_pkg::lcs_fg_ctl_t fg_ctl [lcs_pkg::NUM_FG];
  logic [lcs_pkg::NUM_FG-1:0] fg_dout;
  logic [lcs_pkg::FG_DEPTH-1:0] fg_content [lcs_pkg::NUM_FG];
  logic [lcs_pkg::NUM_FG-1:0] init_load;
  logic [lcs_pkg::NUM_FG-1:0] se_q_nxt;
  logic [lcs_pkg::NUM_FG-1:0] se_aclr;
  logic [lcs_pkg::NUM_FG-1:0] se_apre;
  int sel;

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------
  // Log2 of the number of 16-word banks that one data bit spans on one port.
  function automatic int org_klog(input lcs_pkg::lcs_org_t org);
    int k;
    k = 0;
    unique case (org)
      lcs_pkg::ORG_SP16X8: k = 0;
      lcs_pkg::ORG_SP32X4: k = 1;
      lcs_pkg::ORG_SP64X2: k = 2;
      lcs_pkg::ORG_SP128X1: k = 3;
      lcs_pkg::ORG_DP16X4: k = 0;
      lcs_pkg::ORG_DP32X2: k = 1;
      lcs_pkg::ORG_DP64X1: k = 2;
      default: k = 0;
    endcase
    return k;
  endfunction

  // True when the organisation keeps a read-only copy of every bank.
  function automatic logic org_dual(input lcs_pkg::lcs_org_t org);
    logic d;
    d = 1'h0;
    unique case (org)
      lcs_pkg::ORG_DP16X4, lcs_pkg::ORG_DP32X2, lcs_pkg::ORG_DP64X1: d = 1'h1;
      default: d = 1'h0;
    endcase
    return d;
  endfunction

  // Register decode: 0..3 fixed registers, 4..11 content words, -1 unmapped.
  function automatic int reg_index(input logic [11:0] addr);
    int r;
    r = -1;
    if (addr[1:0] == 2'h0) begin
      if (addr == lcs_pkg::OFS_CTRL) begin
        r = 0;
      end else if (addr == lcs_pkg::OFS_GMODE) begin
        r = 1;
      end else if (addr == lcs_pkg::OFS_SECFG) begin
        r = 2;
      end else if (addr == lcs_pkg::OFS_STATUS) begin
        r = 3;
      end else if (addr >= lcs_pkg::OFS_INIT0 && addr <= lcs_pkg::OFS_INIT_LAST) begin
        r = 4 + int'((addr - lcs_pkg::OFS_INIT0) >> 2);
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------------------
  // Function generators
  // ---------------------------------------------------------------------------
  // Two generators per slice, four slices; slice s owns generators 2s and 2s+1.
  for (genvar g = 0; g < lcs_pkg::NUM_FG; g++) begin : g_fg
    lcs_fgen u_fgen (
      .pclk(pclk),
      .presetn(presetn),
      .ctl(fg_ctl[g]),
      .dout(fg_dout[g]),
      .content(fg_content[g])
    );
  end

  // ---------------------------------------------------------------------------
  // Memory organisation
  // ---------------------------------------------------------------------------
  // Every organisation uses all eight generators: data bit b owns a group of
  // banks, and in dual mode the group's upper half is the read-only copy.
  // The combining mux is shared by all organisations to keep the area small.
  always_comb begin
    int klog;
    int gsize;
    int bit_i;
    int prt;
    int bnk;
    int wbank;
    int dbank;
    logic dual;
    klog = org_klog(st_r.org);
    dual = org_dual(st_r.org);
    gsize = (dual ? 2 : 1) << klog;
    wbank = int'(ram_addr[6:4]) & ((1 << klog) - 1);
    dbank = int'(ram_dpra[5:4]) & ((1 << klog) - 1);
    bit_i = 0;
    prt = 0;
    bnk = 0;
    ram_spo = '0;
    ram_dpo = '0;
    for (int g = 0; g < lcs_pkg::NUM_FG; g++) begin
      bit_i = g / gsize;
      prt = (g % gsize) >> klog;
      bnk = (g % gsize) & ((1 << klog) - 1);
      fg_ctl[g].mode = lcs_pkg::lcs_fmode_t'(st_r.gmode[2*g +: 2]);
      fg_ctl[g].shift_en = shift_en[g];
      fg_ctl[g].shift_in = shift_in[g];
      fg_ctl[g].load = init_load[g];
      fg_ctl[g].load_data = pwdata[lcs_pkg::FG_DEPTH-1:0];
      // Both copies share the write address and data; the enable is per slice, and in 32x2 and 64x1 the copy sits in other slices than the port.
      fg_ctl[g].write_address_input = ram_addr[3:0];
      fg_ctl[g].wdata = ram_wdata[bit_i];
      fg_ctl[g].we = set_reset_input[g / lcs_pkg::FG_PER_SLICE] && (bnk == wbank);
      if (fg_ctl[g].mode == lcs_pkg::FM_RAM) begin
        if (prt == 0) begin
          fg_ctl[g].read_address_input = ram_addr[3:0];
        end else begin
          fg_ctl[g].read_address_input = ram_dpra[3:0];
        end
      end else begin
        fg_ctl[g].read_address_input = read_address_input[4*g +: 4];
      end
      // Output select: the bank picked by the upper address bits drives the bit.
      if (prt == 0 && bnk == wbank) begin
        ram_spo[bit_i] = fg_dout[g];
      end
      if (prt == 1 && bnk == dbank && bit_i < lcs_pkg::DP_WIDTH) begin
        ram_dpo[bit_i] = fg_dout[g];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Storage elements
  // ---------------------------------------------------------------------------
  // Element e of the cluster captures generator e, so a registered read of one
  // 16-word bank is just this element in flip-flop mode on the shared pclk. The
  // asynchronous options act on se_q at once and are stored at the next edge;
  // a latch is transparent while its slice gate is high and holds otherwise.
  always_comb begin
    lcs_pkg::lcs_secfg_t cfg;
    logic rst;
    logic set;
    logic srst;
    logic sset;
    logic val;
    logic gate;
    cfg = '0;
    rst = 1'h0;
    set = 1'h0;
    srst = 1'h0;
    sset = 1'h0;
    val = 1'h0;
    gate = 1'h0;
    for (int e = 0; e < lcs_pkg::NUM_FG; e++) begin
      cfg = lcs_pkg::lcs_secfg_t'(st_r.secfg[lcs_pkg::SECFG_BITS*e +: lcs_pkg::SECFG_BITS]);
      rst = set_reset_input[e / lcs_pkg::FG_PER_SLICE];
      set = set_input[e / lcs_pkg::FG_PER_SLICE];
      gate = latch_gate[e / lcs_pkg::FG_PER_SLICE];
      se_aclr[e] = rst && (cfg.opt == lcs_pkg::SO_ACLR || cfg.opt == lcs_pkg::SO_ABOTH);
      se_apre[e] = set && (cfg.opt == lcs_pkg::SO_APRE || cfg.opt == lcs_pkg::SO_ABOTH);
      srst = rst && (cfg.opt == lcs_pkg::SO_SRST || cfg.opt == lcs_pkg::SO_SBOTH);
      sset = set && (cfg.opt == lcs_pkg::SO_SSET || cfg.opt == lcs_pkg::SO_SBOTH);
      // Synchronous reset is tested first, so it wins over set.
      if (srst) begin
        val = 1'h0;
      end else if (sset) begin
        val = 1'h1;
      end else begin
        val = fg_dout[e];
      end
      // Clear is tested before preset, so it wins when both are active.
      if (se_aclr[e]) begin
        se_q_nxt[e] = 1'h0;
        se_q[e] = 1'h0;
      end else if (se_apre[e]) begin
        se_q_nxt[e] = 1'h1;
        se_q[e] = 1'h1;
      end else if (cfg.latch) begin
        se_q_nxt[e] = gate ? val : st_r.q[e];
        se_q[e] = gate ? val : st_r.q[e];
      end else begin
        se_q_nxt[e] = val;
        se_q[e] = st_r.q[e];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // APB register file
  // ---------------------------------------------------------------------------
  // Read data and the error flag are caught in the setup cycle, so they come
  // from flip-flops yet the slave still answers in the first access cycle.
  always_comb begin
    sel = reg_index(paddr);
    st_nxt = st_r;
    st_nxt.q = se_q_nxt;
    init_load = '0;
    if (psel && !penable) begin
      st_nxt.slverr = (sel < 0);
      unique case (sel)
        0: st_nxt.prdata = {29'h0, st_r.org};
        1: st_nxt.prdata = {16'h0, st_r.gmode};
        2: st_nxt.prdata = st_r.secfg;
        3: st_nxt.prdata = {16'h0, fg_dout, se_q};
        4, 5, 6, 7, 8, 9, 10, 11: st_nxt.prdata = {16'h0, fg_content[sel - 4]};
        default: st_nxt.prdata = 32'h00000000;
      endcase
    end
    // A write takes effect at the access edge; status and unmapped are ignored.
    if (psel && penable && pwrite) begin
      unique case (sel)
        0: st_nxt.org = lcs_pkg::lcs_org_t'(pwdata[2:0]);
        1: st_nxt.gmode = pwdata[15:0];
        2: st_nxt.secfg = pwdata;
        4, 5, 6, 7, 8, 9, 10, 11: init_load[sel - 4] = 1'h1;
        default: st_nxt.slverr = st_r.slverr;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.org <= lcs_pkg::lcs_org_t'(lcs_pkg::RST_ORG);
      st_r.gmode <= lcs_pkg::RST_GMODE;
      st_r.secfg <= lcs_pkg::RST_SECFG;
      st_r.q <= '0;
      st_r.prdata <= 32'h00000000;
      st_r.slverr <= 1'h0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // Zero wait states: every access phase completes in its first cycle.
  assign pready = 1'h1;
  assign prdata = st_r.prdata;
  assign pslverr = st_r.slverr && psel && penable;
  assign fg_out = fg_dout;

  // The last stage of each shift register, for cascading in user logic.
  always_comb begin
    for (int g = 0; g < lcs_pkg::NUM_FG; g++) begin
      shift_out[g] = fg_content[g][lcs_pkg::FG_DEPTH-1];
    end
  end

endmodule

/* File: core/lcs_pkg.sv */
// Constants, types and carriers shared by the logic cluster and its function generator.
// Assumes one clock (pclk, 50 MHz) and an APB master that owns the register side.
//
// Function
// - A cluster holds four equal slices, each with two generators and two elements.
// - Each generator acts as a 4-input lookup table, 16-bit shift register or RAM.
// - Each storage element is either an edge flip-flop or a level latch.
// - Elements offer none, sync set, sync reset, both, async preset, clear, or both.
// - Synchronous reset beats synchronous set on the same edge.
// - Asynchronous clear beats asynchronous preset when both are active.
// - A generator in memory use holds sixteen one-bit words.
// - Single-port memories are 16x8, 32x4, 64x2 or 128x1 within one cluster.
// - Dual-port memories are 16x4, 32x2 or 64x1 within one cluster.
// - Memory writes happen on the clock edge; reads follow the address combinationally.
// - A registered read comes from a storage element on the same clock.
// - Write enable is active high and comes from the slice set/reset input.
// - Generators used: 16S 1, 16D 2, 32S 2, 32D 4, 64S 4, 64D 8, 128S 8.
// - Single-port memories read and write through one shared address.
// - Each generator has four read-address and four write-address inputs.
// - The dual-port copy reads its own address but shares every write; in 32x2 and 64x1 its write enable is another slice's input.

package lcs_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int NUM_SLICES = 4;
  localparam int FG_PER_SLICE = 2;
  localparam int NUM_FG = NUM_SLICES * FG_PER_SLICE;
  localparam int FG_DEPTH = 16;
  localparam int FG_ABITS = 4;
  localparam int RAM_ABITS = 7;
  localparam int DP_ABITS = 6;
  localparam int DP_WIDTH = 4;
  localparam int SECFG_BITS = 4;

  // ---------------------------------------------------------------------------
  // Register map and reset values
  // ---------------------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_GMODE = 12'h004;
  localparam logic [11:0] OFS_SECFG = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00C;
  localparam logic [11:0] OFS_INIT0 = 12'h010;
  localparam logic [11:0] OFS_INIT_LAST = 12'h02C;
  localparam logic [2:0] RST_ORG = 3'h0;
  localparam logic [15:0] RST_GMODE = 16'h0000;
  localparam logic [31:0] RST_SECFG = 32'h00000000;
  localparam logic [15:0] RST_CONTENT = 16'h0000;

  // ---------------------------------------------------------------------------
  // Modes
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {FM_LUT, FM_SHIFT, FM_RAM} lcs_fmode_t;

  typedef enum logic [2:0] {
    ORG_SP16X8, ORG_SP32X4, ORG_SP64X2, ORG_SP128X1, ORG_DP16X4, ORG_DP32X2, ORG_DP64X1
  } lcs_org_t;

  typedef enum logic [2:0] {
    SO_NONE, SO_SSET, SO_SRST, SO_SBOTH, SO_APRE, SO_ACLR, SO_ABOTH
  } lcs_sropt_t;

  typedef struct packed {
    logic latch;
    lcs_sropt_t opt;
  } lcs_secfg_t;

  // ---------------------------------------------------------------------------
  // Carriers and state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    lcs_fmode_t mode;
    logic [FG_ABITS-1:0] read_address_input;
    logic [FG_ABITS-1:0] write_address_input;
    logic wdata;
    logic we;
    logic shift_en;
    logic shift_in;
    logic load;
    logic [FG_DEPTH-1:0] load_data;
  } lcs_fg_ctl_t;

  typedef struct packed {
    logic [FG_DEPTH-1:0] content;
  } lcs_fg_state_t;

  typedef struct packed {
    lcs_org_t org;
    logic [15:0] gmode;
    logic [31:0] secfg;
    logic [NUM_FG-1:0] q;
    logic [31:0] prdata;
    logic slverr;
  } lcs_top_state_t;

endpackage

/* File: core/lcs_fgen.sv */
// One function generator: sixteen bits of content used as table, shift register or RAM.
// Assumes its controls come from logic on pclk; it holds no address decoding of its own.
`timescale 1ns/1ps

module lcs_fgen (
  input wire logic pclk,
  input wire logic presetn,
  input lcs_pkg::lcs_fg_ctl_t ctl,
  output logic dout,
  output logic [lcs_pkg::FG_DEPTH-1:0] content
);

  lcs_pkg::lcs_fg_state_t st_r;
  lcs_pkg::lcs_fg_state_t st_nxt;

  // ---------------------------------------------------------------------------
  // Next content
  // ---------------------------------------------------------------------------
  // A register load wins over user activity so software always sees what it wrote.
  always_comb begin
    st_nxt = st_r;
    if (ctl.load) begin
      st_nxt.content = ctl.load_data;
    end else begin
      unique case (ctl.mode)
        lcs_pkg::FM_LUT: begin
          st_nxt = st_r;
        end
        lcs_pkg::FM_SHIFT: begin
          if (ctl.shift_en) begin
            st_nxt.content = {st_r.content[lcs_pkg::FG_DEPTH-2:0], ctl.shift_in};
          end
        end
        lcs_pkg::FM_RAM: begin
          if (ctl.we) begin
            st_nxt.content[ctl.write_address_input] = ctl.wdata;
          end
        end
        default: begin
          st_nxt = st_r;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // Writes land only here, on the edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.content <= lcs_pkg::RST_CONTENT;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Read side
  // ---------------------------------------------------------------------------
  // The read is a pure mux, so data follows the read address with no clock.
  assign dout = st_r.content[ctl.read_address_input];
  assign content = st_r.content;

endmodule

/* File: dv/lcs_cluster_asserts.sv */
// Checker of the logic cluster, bound to its top module and seeing only its ports.
// Assumes configuration changes only through APB writes to CTRL, GMODE and SECFG.
`timescale 1ns/1ps

module lcs_cluster_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [31:0] read_address_input,
  input wire logic [7:0] shift_en,
  input wire logic [6:0] ram_addr,
  input wire logic [5:0] ram_dpra,
  input wire logic [7:0] ram_wdata,
  input wire logic [3:0] set_reset_input,
  input wire logic [3:0] set_input,
  input wire logic [7:0] fg_out,
  input wire logic [7:0] shift_out,
  input wire logic [7:0] ram_spo,
  input wire logic [3:0] ram_dpo,
  input wire logic [7:0] se_q
);
  // ----------------------------------------------------------------
  // Configuration shadow
  // ----------------------------------------------------------------
  logic [2:0] org_s;
  logic [15:0] gmode_s;
  logic [3:0] secfg_s;

  // Updated at the access edge, the same edge on which the design stores a write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      org_s <= 3'h0;
      gmode_s <= 16'h0000;
      secfg_s <= 4'h0;
    end else if (psel && penable && pwrite) begin
      if (paddr == lcs_pkg::OFS_CTRL) org_s <= pwdata[2:0];
      if (paddr == lcs_pkg::OFS_GMODE) gmode_s <= pwdata[15:0];
      if (paddr == lcs_pkg::OFS_SECFG) secfg_s <= pwdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // No bus access, no shift and no write enable: no content may change.
  sequence sq_quiet;
    !psel && shift_en == 8'h00 && set_reset_input == 4'h0;
  endsequence
  // Cluster-wide memory write with every generator in memory use.
  sequence sq_ram_wr;
    !psel && gmode_s == 16'hAAAA && set_reset_input == 4'hF;
  endsequence

  AST_PREADY: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  AST_ERR_WINDOW: assert property (pslverr |-> psel && penable)
    else $error("error flag outside access phase");
  AST_SHIFT_HOLD: assert property (sq_quiet |=> $stable(shift_out))
    else $error("shift output moved without a shift");
  AST_LUT_COMB: assert property (sq_quiet ##1 $stable(read_address_input) &&
    $stable(ram_addr) && $stable(ram_dpra) |-> $stable(fg_out))
    else $error("table output moved with fixed address");
  AST_SP_WRITE: assert property (sq_ram_wr ##0 org_s == 3'h0 ##1 $stable(ram_addr)
    |-> ram_spo == $past(ram_wdata))
    else $error("memory read differs from data just written");
  AST_NO_WE: assert property (!psel && gmode_s == 16'hAAAA && set_reset_input == 4'h0
    ##1 $stable(ram_addr) |-> $stable(ram_spo))
    else $error("memory changed without write enable");
  AST_DP_COPY: assert property (sq_ram_wr ##0 org_s inside {3'h4, 3'h5, 3'h6}
    ##1 $stable(ram_addr) && ram_dpra == ram_addr[5:0]
    |-> ram_dpo == ram_spo[3:0] && ram_spo[7:4] == 4'h0)
    else $error("read-only copy differs from written port");
  AST_FLOP: assert property (secfg_s == 4'h0 |=> se_q[0] == $past(fg_out[0]))
    else $error("element did not capture generator output");
  AST_SYNC_PRIO: assert property (secfg_s == 4'h3 && set_reset_input[0] |=> !se_q[0])
    else $error("synchronous set beat reset");
  AST_ASYNC_CLR: assert property (secfg_s inside {4'h5, 4'h6} && set_reset_input[0]
    |-> !se_q[0])
    else $error("asynchronous clear not applied at once");
  AST_ASYNC_PRE: assert property (secfg_s == 4'h4 && set_input[0] |-> se_q[0])
    else $error("asynchronous preset not applied at once");
endmodule

bind lcs_cluster lcs_cluster_asserts chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .read_address_input(read_address_input), .shift_en(shift_en), .ram_addr(ram_addr),
  .ram_dpra(ram_dpra), .ram_wdata(ram_wdata), .set_reset_input(set_reset_input),
  .set_input(set_input), .fg_out(fg_out), .shift_out(shift_out), .ram_spo(ram_spo),
  .ram_dpo(ram_dpo), .se_q(se_q)
);

/* File: dv/lcs_user_model.sv */
// User logic beside the cluster: drives memory address, write data and set/reset.
// Assumes commands from the bench arrive on pclk; it answers one edge later.
`timescale 1ns/1ps

module lcs_user_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic [6:0] addr,
  input wire logic [7:0] data,
  input wire logic [3:0] srmask,
  output logic [6:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic [3:0] set_reset_input
);
  // Idle write data toggles so that no stale value can pass for a real write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_addr <= 7'h00;
      ram_wdata <= 8'h00;
      set_reset_input <= 4'h0;
    end else begin
      ram_addr <= addr;
      set_reset_input <= req ? 4'hF : srmask;
      ram_wdata <= req ? data : ~ram_wdata;
    end
  end
endmodule

/* File: dv/lcs_cluster_test.sv */
// Self-checking bench of the logic cluster with an APB master and a user-logic model.
// Assumes the cluster answers every access phase at once and has no parameters.
`timescale 1ns/1ps

module lcs_cluster_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, read_address_input = 32'h00000000;
  logic [7:0] shift_en = 8'h00, shift_in = 8'h00, usr_data = 8'h00;
  logic [6:0] usr_addr = 7'h00;
  logic [5:0] ram_dpra = 6'h00;
  logic [3:0] set_input = 4'h0, latch_gate = 4'h0, usr_srmask = 4'h0;
  logic usr_req = 1'b0, pready, pslverr;
  logic [31:0] prdata;
  logic [6:0] ram_addr;
  logic [7:0] ram_wdata, fg_out, shift_out, ram_spo, se_q;
  logic [3:0] set_reset_input, ram_dpo;
  int failures = 0, checks = 0;

  // Half period of the 50 MHz clock.
  always #10 pclk = ~pclk;

  lcs_cluster dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .read_address_input(read_address_input), .shift_en(shift_en),
    .shift_in(shift_in), .ram_addr(ram_addr), .ram_dpra(ram_dpra), .ram_wdata(ram_wdata),
    .set_reset_input(set_reset_input), .set_input(set_input), .latch_gate(latch_gate),
    .fg_out(fg_out), .shift_out(shift_out), .ram_spo(ram_spo), .ram_dpo(ram_dpo),
    .se_q(se_q));
  lcs_user_model usr_u (.pclk(pclk), .presetn(presetn), .req(usr_req), .addr(usr_addr),
    .data(usr_data), .srmask(usr_srmask), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .set_reset_input(set_reset_input));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One transfer; request held until ready is seen high, then released for one idle cycle.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    cyc(1);
    penable <= 1'b1;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      failures++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    cyc(1);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp,
                       input logic eexp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h00000000, rd, err);
    chk(nm, rd, exp);
    chk("error flag", {31'h0, err}, {31'h0, eexp});
  endtask

  // The model drives the write one edge after the command; the cluster writes the next.
  task automatic uwrite(input logic [6:0] a, input logic [7:0] d);
    usr_addr <= a;
    usr_data <= d;
    usr_req <= 1'b1;
    cyc(1);
    usr_req <= 1'b0;
    cyc(2);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdchk("org", lcs_pkg::OFS_CTRL, 32'h00000000, 1'b0);
    rdchk("modes", lcs_pkg::OFS_GMODE, 32'h00000000, 1'b0);
    rdchk("elements", lcs_pkg::OFS_SECFG, 32'h00000000, 1'b0);
    wr(lcs_pkg::OFS_CTRL, 32'h00000007);
    rdchk("org code", lcs_pkg::OFS_CTRL, 32'h00000007, 1'b0);
    wr(12'h0F0, 32'hFFFFFFFF);
    rdchk("unmapped", 12'h0F0, 32'h00000000, 1'b1);
  endtask

  // Table read at every address of generator one, then one shift step.
  task automatic t_lut_shift();
    logic [15:0] pat;
    pat = 16'hA3C5;
    wr(lcs_pkg::OFS_INIT0 + 12'h004, {16'h0, pat});
    for (int a = 0; a < 16; a++) begin
      read_address_input <= {24'h0, a[3:0], 4'h0};
      cyc(1);
      chk("table", {31'h0, fg_out[1]}, {31'h0, pat[a]});
    end
    rdchk("content", lcs_pkg::OFS_INIT0 + 12'h004, {16'h0, pat}, 1'b0);
    wr(lcs_pkg::OFS_GMODE, 32'h00000004);
    shift_en <= 8'h02;
    shift_in <= 8'h02;
    cyc(1);
    shift_en <= 8'h00;
    cyc(1);
    chk("shift out", {31'h0, shift_out[1]}, 32'h00000000);
    rdchk("shifted", lcs_pkg::OFS_INIT0 + 12'h004, 32'h0000478B, 1'b0);
  endtask

  // Every organisation: write its last word, read both ports, then idle with no enable.
  task automatic t_ram();
    logic [7:0] d, m;
    logic [6:0] a;
    for (int g = 0; g < 8; g++) wr(lcs_pkg::OFS_INIT0 + 12'(4 * g), 32'h00000000);
    wr(lcs_pkg::OFS_GMODE, 32'h0000AAAA);
    for (int o = 0; o < 7; o++) begin
      m = (o < 4) ? 8'((1 << (8 >> o)) - 1) : 8'((1 << (4 >> (o - 4))) - 1);
      a = (o < 4) ? 7'((16 << o) - 1) : 7'((16 << (o - 4)) - 1);
      d = o[0] ? 8'hA5 : 8'h5A;
      wr(lcs_pkg::OFS_CTRL, 32'(o));
      ram_dpra <= a[5:0];
      uwrite(a, d);
      chk("port read", {24'h0, ram_spo}, {24'h0, d & m});
      chk("copy read", {28'h0, ram_dpo}, (o < 4) ? 32'h0 : {24'h0, d & m});
      cyc(3);
      chk("kept", {24'h0, ram_spo}, {24'h0, d & m});
    end
  endtask

  // Table rows: element config, set, reset, generator value, expected output.
  task automatic t_elem();
    logic [7:0] tbl [8];
    tbl = '{8'h03, 8'h19, 8'h26, 8'h3C, 8'h49, 8'h56, 8'h6C, 8'h83};
    wr(lcs_pkg::OFS_GMODE, 32'h00000000);
    latch_gate <= 4'h1;
    for (int r = 0; r < 8; r++) begin
      wr(lcs_pkg::OFS_INIT0, tbl[r][1] ? 32'h0000FFFF : 32'h00000000);
      wr(lcs_pkg::OFS_SECFG, {28'h0, tbl[r][7:4]});
      set_input <= {3'h0, tbl[r][3]};
      usr_srmask <= {3'h0, tbl[r][2]};
      cyc(3);
      chk("element", {31'h0, se_q[0]}, {31'h0, tbl[r][0]});
      set_input <= 4'h0;
      usr_srmask <= 4'h0;
      cyc(2);
    end
    // Gate low: the latch must hold its 1 while the generator drops to 0.
    latch_gate <= 4'h0;
    wr(lcs_pkg::OFS_INIT0, 32'h00000000);
    chk("latch held", {31'h0, se_q[0]}, 32'h00000001);
  endtask

  // Main sequence.
  initial begin
    cyc(5);
    presetn <= 1'b1;
    cyc(1);
    t_reset();
    t_lut_shift();
    t_ram();
    t_elem();
    end_of_test();
  end
endmodule
